// ===== inc/pkh_pkg.sv
// Constants, types and shared helpers for the two-wire keyboard/mouse host.
// Assumes a 100 MHz system clock and classic Wishbone register access.
// Function
// - Both lines released high when idle
// - Word: start, eight LSB-first bits, odd parity, stop
// - Host holds clock low to inhibit sending
// - Open-collector drive; either side pulls low
// - Release is F0 then the key code
// - Extended keys: E0 prefix, release E0 F0 code
// - Host tracks shift state itself
// - ED, reply FA, then LED byte follows
// - F3, acknowledge, then repeat-rate byte follows
// - Mouse packet: status, horizontal, vertical bytes
// - Signed displacement; sign flags one for negative
// - Report horizontal and vertical overflow flags
// - Extract left and right button flags
package pkh_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  // Host request: clock held low at least this long
  localparam int unsigned INHIBIT_NS    = 100000;
  localparam int unsigned INHIBIT_CYC   = (INHIBIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Partial frame abandoned after this silence
  localparam int unsigned FRAME_TMO_NS  = 2000000;
  localparam int unsigned FRAME_TMO_CYC = FRAME_TMO_NS / CLK_PERIOD_NS;
  // Peripheral may take many ms to start clocking a host word
  localparam int unsigned TX_TMO_NS     = 20000000;
  localparam int unsigned TX_TMO_CYC    = TX_TMO_NS / CLK_PERIOD_NS;
  localparam int unsigned TMO_W         = 22;

  localparam logic [3:0] FRAME_LAST = 4'd10;
  localparam logic [3:0] TX_PAR_BIT = 4'd8;
  localparam logic [3:0] TX_STOP_BIT = 4'd9;

  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_STAT  = 8'h04;
  localparam logic [7:0] ADR_KEY   = 8'h08;
  localparam logic [7:0] ADR_MXY   = 8'h0C;
  localparam logic [7:0] ADR_MBTN  = 8'h10;
  localparam logic [7:0] ADR_TX    = 8'h14;
  localparam logic [7:0] ADR_ARG   = 8'h18;

  localparam int unsigned CTL_INHIBIT = 0;
  localparam int unsigned CTL_MOUSE   = 1;
  localparam logic [1:0]  CTRL_RST    = 2'h0;

  localparam int unsigned ST_KEY   = 0;
  localparam int unsigned ST_MOUSE = 1;
  localparam int unsigned ST_ERR   = 2;
  localparam int unsigned ST_ACK   = 3;
  localparam int unsigned ST_ECHO  = 4;
  localparam int unsigned ST_TXERR = 5;

  localparam int unsigned MS_LEFT  = 0;
  localparam int unsigned MS_RIGHT = 1;
  localparam int unsigned MS_ONE   = 3;
  localparam int unsigned MS_XSIGN = 4;
  localparam int unsigned MS_YSIGN = 5;
  localparam int unsigned MS_XOVF  = 6;
  localparam int unsigned MS_YOVF  = 7;

  localparam logic [7:0] CODE_EXT     = 8'hE0;
  localparam logic [7:0] CODE_RELEASE = 8'hF0;
  localparam logic [7:0] CODE_ACK     = 8'hFA;
  localparam logic [7:0] CODE_ECHO    = 8'hEE;
  localparam logic [7:0] CMD_LED      = 8'hED;
  localparam logic [7:0] CMD_RATE     = 8'hF3;
  localparam logic [7:0] SHIFT_LEFT   = 8'h12;
  localparam logic [7:0] SHIFT_RIGHT  = 8'h59;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_HOLD = 3'b001,
    TX_SEND = 3'b010,
    TX_ACK  = 3'b011,
    TX_WAIT = 3'b100
  } pkh_tx_e;

  function automatic logic odd_par(input logic [7:0] b);
    return ~(^b);
  endfunction

endpackage

// ===== inc/pkh_line_if.sv
// Interface: deglitched line levels and clock-fall pulse.
// Driven by the synchroniser, read by receiver and host logic.
`timescale 1ns/10ps
interface pkh_line_if;
  logic clk_lvl;
  logic dat_lvl;
  logic clk_fall;
  modport src (output clk_lvl, output dat_lvl, output clk_fall);
  modport dst (input clk_lvl, input dat_lvl, input clk_fall);
endinterface

// ===== rtl/pkh_line_sync.sv
// Three-stage synchroniser and agreement filter for both link lines.
// Assumes pins are asynchronous to clk_i; idle level is high.
`timescale 1ns/10ps
module pkh_line_sync
  import pkh_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ps2_clk_i,
  input  wire logic ps2_dat_i,
  pkh_line_if.src   line
);

  logic [2:0] clk_sh;
  logic [2:0] dat_sh;
  wire        clk_agree = clk_sh[1] == clk_sh[2];
  wire        dat_agree = dat_sh[1] == dat_sh[2];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_sh        <= 3'h7;
      dat_sh        <= 3'h7;
      line.clk_lvl  <= 1'b1;
      line.dat_lvl  <= 1'b1;
      line.clk_fall <= 1'b0;
    end
    else
    begin
      clk_sh        <= {clk_sh[1:0], ps2_clk_i};
      dat_sh        <= {dat_sh[1:0], ps2_dat_i};
      // One-sample glitches never reach the edge detector
      line.clk_lvl  <= clk_agree ? clk_sh[2] : line.clk_lvl;
      line.dat_lvl  <= dat_agree ? dat_sh[2] : line.dat_lvl;
      line.clk_fall <= line.clk_lvl & clk_agree & ~clk_sh[2];
    end
  end

endmodule // pkh_line_sync

// ===== rtl/pkh_frame_rx.sv
// Eleven-bit word receiver clocked by the filtered clock-fall pulse.
// Assumes en_i drops while the host itself drives the link.
`timescale 1ns/10ps
module pkh_frame_rx
  import pkh_pkg::*;
#(
  parameter int unsigned TMO_CYC = FRAME_TMO_CYC
)(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  pkh_line_if.dst         line,
  output logic      [7:0] byte_o,
  output logic            valid_o,
  output logic            err_o
);

  logic [10:0]      sh;
  logic [3:0]       cnt;
  logic [TMO_W-1:0] idle;
  wire  [10:0]      word     = {line.dat_lvl, sh[10:1]};
  wire              word_ok  = ~word[0] & word[10] & (word[9] == odd_par(word[8:1]));
  wire              tmo      = idle == TMO_W'(TMO_CYC - 1);

  always_ff @(posedge clk_i)
  begin
    if (rst_i | ~en_i)
    begin
      sh      <= 11'h7FF;
      cnt     <= 4'h0;
      idle    <= '0;
      byte_o  <= 8'h00;
      valid_o <= 1'b0;
      err_o   <= 1'b0;
    end
    else
    begin
      valid_o <= 1'b0;
      err_o   <= 1'b0;
      if (line.clk_fall)
      begin
        sh   <= word;
        idle <= '0;
        cnt  <= (cnt == FRAME_LAST) ? 4'h0 : cnt + 4'h1;
        if (cnt == FRAME_LAST)
        begin
          valid_o <= word_ok;
          err_o   <= ~word_ok;
          if (word_ok)
            byte_o <= word[8:1];
        end
      end
      else if (cnt != 4'h0)
      begin
        // Lost edge: drop the partial word rather than misalign the next
        idle <= tmo ? '0 : idle + 1'b1;
        if (tmo)
        begin
          cnt   <= 4'h0;
          err_o <= 1'b1;
        end
      end
    end
  end

endmodule // pkh_frame_rx

// ===== rtl/pkh_host.sv
// Two-wire keyboard/mouse host: receive, decode, command send, Wishbone regs.
// Assumes open-drain pads outside; an enable high pulls that line low.
`timescale 1ns/10ps
module pkh_host
  import pkh_pkg::*;
#(
  parameter int unsigned INHIBIT_CYC_P = INHIBIT_CYC,
  parameter int unsigned FRAME_TMO_P   = FRAME_TMO_CYC,
  parameter int unsigned TX_TMO_P      = TX_TMO_CYC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ps2_clk_i,
  output logic             ps2_clk_o,
  output logic             ps2_clk_oe_o,
  input  wire logic        ps2_dat_i,
  output logic             ps2_dat_o,
  output logic             ps2_dat_oe_o
);

  pkh_line_if line ();

  logic [7:0]       rx_byte;
  logic             rx_valid;
  logic             rx_err;
  logic             rx_en;

  logic [1:0]       ctrl;
  logic [5:0]       status;
  logic [7:0]       arg;
  logic [7:0]       last_rx;
  logic [7:0]       key_code;
  logic             key_rel;
  logic             key_ext;
  logic             shift_held;
  logic             ext_pend;
  logic             rel_pend;
  logic [7:0]       p_stat;
  logic [7:0]       p_x;
  logic [7:0]       m_stat;
  logic [7:0]       m_x;
  logic [7:0]       m_y;
  logic [1:0]       m_idx;

  pkh_tx_e          tx_state;
  pkh_tx_e          next_tx_state;
  logic [7:0]       tx_byte;
  logic [3:0]       tx_bit;
  logic             arg_phase;
  logic [TMO_W-1:0] tcnt;
  logic             dat_drv;

  pkh_line_sync u_sync (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ps2_clk_i (ps2_clk_i),
    .ps2_dat_i (ps2_dat_i),
    .line      (line)
  );

  pkh_frame_rx #(
    .TMO_CYC (FRAME_TMO_P)
  ) u_rx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (rx_en),
    .line    (line),
    .byte_o  (rx_byte),
    .valid_o (rx_valid),
    .err_o   (rx_err)
  );

  // Bus decode
  wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
  wire [5:0]  wb_word  = wb_adr_i[7:2];
  wire        hit_ctrl = wb_word == ADR_CTRL[7:2];
  wire        hit_stat = wb_word == ADR_STAT[7:2];
  wire        hit_key  = wb_word == ADR_KEY[7:2];
  wire        hit_mxy  = wb_word == ADR_MXY[7:2];
  wire        hit_mbtn = wb_word == ADR_MBTN[7:2];
  wire        hit_tx   = wb_word == ADR_TX[7:2];
  wire        hit_arg  = wb_word == ADR_ARG[7:2];

  // Link-side decode
  wire        tx_busy  = tx_state != TX_IDLE;
  wire        kb_mode  = ~ctrl[CTL_MOUSE];
  wire        is_ext   = rx_byte == CODE_EXT;
  wire        is_rel   = rx_byte == CODE_RELEASE;
  wire        is_ack   = rx_byte == CODE_ACK;
  wire        is_echo  = rx_byte == CODE_ECHO;
  wire        is_shift = (rx_byte == SHIFT_LEFT) | (rx_byte == SHIFT_RIGHT);
  wire        kb_byte  = rx_valid & kb_mode;
  wire        key_evt  = kb_byte & ~is_ext & ~is_rel & ~is_ack & ~is_echo;
  wire        ms_byte  = rx_valid & ~kb_mode;
  // Status byte always has bit 3 set; use it to realign packets
  wire        ms_bad   = (m_idx == 2'd0) & ~rx_byte[MS_ONE];
  wire        ms_evt   = ms_byte & (m_idx == 2'd2);

  // Transmit timing
  wire        hold_done = tcnt == TMO_W'(INHIBIT_CYC_P - 1);
  wire        tx_tmo    = tcnt == TMO_W'(TX_TMO_P - 1);
  wire        tx_start  = wb_wr & hit_tx & ~tx_busy;
  wire        needs_arg = ((tx_byte == CMD_LED) | (tx_byte == CMD_RATE)) & ~arg_phase;
  wire        ack_fall  = (tx_state == TX_ACK) & line.clk_fall;
  wire        arg_go    = (tx_state == TX_WAIT) & rx_valid & is_ack;
  wire        tx_wait   = (tx_state == TX_SEND) | (tx_state == TX_ACK) | (tx_state == TX_WAIT);
  wire        tx_fail   = (tx_wait & tx_tmo) | (ack_fall & line.dat_lvl);

  // Sticky flags: a set in the clearing cycle survives
  wire [5:0]  st_clr = (wb_wr & hit_stat) ? wb_dat_i[5:0] : 6'h00;
  wire [5:0]  st_set = {tx_fail,
                        kb_byte & is_echo,
                        kb_byte & is_ack,
                        rx_err,
                        ms_evt & ~ms_bad,
                        key_evt};

  // Read data words
  wire [31:0] rd_ctrl = {30'h0, ctrl};
  wire [31:0] rd_stat = {25'h0, tx_busy, status};
  wire [31:0] rd_key  = {21'h0, shift_held, key_ext, key_rel, key_code};
  wire [31:0] rd_mxy  = {7'h00, m_stat[MS_YSIGN], m_y, 7'h00, m_stat[MS_XSIGN], m_x};
  wire [31:0] rd_mbtn = {18'h0,
                         m_stat[MS_YOVF], m_stat[MS_XOVF],
                         m_stat[MS_YSIGN], m_stat[MS_XSIGN],
                         m_stat[MS_RIGHT], m_stat[MS_LEFT],
                         m_stat};
  wire [31:0] rd_rx   = {24'h0, last_rx};
  wire [31:0] rd_arg  = {24'h0, arg};
  wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                        hit_stat ? rd_stat :
                        hit_key  ? rd_key  :
                        hit_mxy  ? rd_mxy  :
                        hit_mbtn ? rd_mbtn :
                        hit_tx   ? rd_rx   :
                        hit_arg  ? rd_arg  : 32'h0000_0000;

  // Lines only pulled low; released otherwise
  assign ps2_clk_o    = 1'b0;
  assign ps2_dat_o    = 1'b0;
  assign ps2_clk_oe_o = (tx_state == TX_HOLD) | (~tx_busy & ctrl[CTL_INHIBIT]);
  assign ps2_dat_oe_o = dat_drv;
  // Receive only while the host leaves the link to the peripheral
  assign rx_en        = (~tx_busy & ~ctrl[CTL_INHIBIT]) | (tx_state == TX_WAIT);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_mux : wb_dat_o;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl    <= CTRL_RST;
      arg     <= 8'h00;
      status  <= 6'h00;
      last_rx <= 8'h00;
    end
    else
    begin
      ctrl    <= (wb_wr & hit_ctrl) ? wb_dat_i[1:0] : ctrl;
      arg     <= (wb_wr & hit_arg) ? wb_dat_i[7:0] : arg;
      status  <= (status & ~st_clr) | st_set;
      last_rx <= rx_valid ? rx_byte : last_rx;
    end
  end

  // Keyboard decode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      key_code   <= 8'h00;
      key_rel    <= 1'b0;
      key_ext    <= 1'b0;
      shift_held <= 1'b0;
      ext_pend   <= 1'b0;
      rel_pend   <= 1'b0;
    end
    else if (rx_err)
    begin
      ext_pend <= 1'b0;
      rel_pend <= 1'b0;
    end
    else if (kb_byte & is_ext)
      ext_pend <= 1'b1;
    else if (kb_byte & is_rel)
      rel_pend <= 1'b1;
    else if (key_evt)
    begin
      key_code <= rx_byte;
      key_rel  <= rel_pend;
      key_ext  <= ext_pend;
      ext_pend <= 1'b0;
      rel_pend <= 1'b0;
      if (is_shift & ~ext_pend)
        shift_held <= ~rel_pend;
    end
  end

  // Mouse packet assembly
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      m_idx  <= 2'd0;
      p_stat <= 8'h00;
      p_x    <= 8'h00;
      m_stat <= 8'h00;
      m_x    <= 8'h00;
      m_y    <= 8'h00;
    end
    else if (rx_err | kb_mode | (ms_byte & ms_bad))
      m_idx <= 2'd0;
    else if (ms_byte)
    begin
      case (m_idx)
        2'd0:
        begin
          p_stat <= rx_byte;
          m_idx  <= 2'd1;
        end
        2'd1:
        begin
          p_x   <= rx_byte;
          m_idx <= 2'd2;
        end
        default:
        begin
          m_stat <= p_stat;
          m_x    <= p_x;
          m_y    <= rx_byte;
          m_idx  <= 2'd0;
        end
      endcase
    end
  end

  // Host-to-peripheral send
  always_comb
  begin
    next_tx_state = tx_state;
    case (tx_state)
      TX_IDLE:
        if (tx_start)
          next_tx_state = TX_HOLD;
      TX_HOLD:
        if (hold_done)
          next_tx_state = TX_SEND;
      TX_SEND:
        if (tx_tmo)
          next_tx_state = TX_IDLE;
        else if (line.clk_fall & (tx_bit == TX_STOP_BIT))
          next_tx_state = TX_ACK;
      TX_ACK:
        if (tx_tmo)
          next_tx_state = TX_IDLE;
        else if (line.clk_fall)
          next_tx_state = (~line.dat_lvl & needs_arg) ? TX_WAIT : TX_IDLE;
      TX_WAIT:
        if (tx_tmo)
          next_tx_state = TX_IDLE;
        else if (arg_go)
          next_tx_state = TX_HOLD;
      default:
        next_tx_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_state <= TX_IDLE;
      tcnt     <= '0;
    end
    else
    begin
      tx_state <= next_tx_state;
      tcnt     <= (next_tx_state != tx_state) ? '0 : tcnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_byte   <= 8'h00;
      arg_phase <= 1'b0;
    end
    else if (tx_start)
    begin
      tx_byte   <= wb_dat_i[7:0];
      arg_phase <= 1'b0;
    end
    else if (arg_go)
    begin
      tx_byte   <= arg;
      arg_phase <= 1'b1;
    end
  end

  // Data bits change after each falling edge; peripheral reads on rising
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_bit  <= 4'h0;
      dat_drv <= 1'b0;
    end
    else if (tx_state == TX_HOLD)
    begin
      tx_bit  <= 4'h0;
      dat_drv <= hold_done;
    end
    else if ((tx_state == TX_SEND) & ~tx_tmo)
    begin
      if (line.clk_fall)
      begin
        tx_bit <= tx_bit + 4'h1;
        if (tx_bit < TX_PAR_BIT)
          dat_drv <= ~tx_byte[tx_bit[2:0]];
        else if (tx_bit == TX_PAR_BIT)
          dat_drv <= ~odd_par(tx_byte);
        else
          dat_drv <= 1'b0;
      end
    end
    else
      dat_drv <= 1'b0;
  end

endmodule // pkh_host

// ===== tb/pkh_host_properties.sv
// Port-level checks for pkh_host: bus handshake and link pin drive.
// Assumes bind into pkh_host; one clock domain, synchronous reset.
`timescale 1ns/10ps
module pkh_host_properties
#(
  parameter int unsigned INHIBIT_CYC_P = 20
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        ps2_clk_i,
  input  wire logic        ps2_clk_o,
  input  wire logic        ps2_clk_oe_o,
  input  wire logic        ps2_dat_o,
  input  wire logic        ps2_dat_oe_o
);
  int unsigned low_cnt;

  // Length of the current host-held clock low
  always_ff @(posedge clk_i)
    if (rst_i || !ps2_clk_oe_o)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  rdata_hold_a: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
    else $error("read data moved without request");
  unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i[7:2] > 6'h06
    |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  idle_release_a: assert property ($past(rst_i) |-> !ps2_clk_oe_o && !ps2_dat_oe_o)
    else $error("line driven after reset");
  open_drain_a: assert property (ps2_clk_o == 1'b0 && ps2_dat_o == 1'b0)
    else $error("pin drives high");
  inhibit_len_a: assert property ($fell(ps2_clk_oe_o) && ps2_dat_oe_o |-> low_cnt >= INHIBIT_CYC_P)
    else $error("clock hold too short");
  data_rise_a: assert property ($rose(ps2_dat_oe_o) |-> !$past(ps2_clk_i))
    else $error("data changed while clock high");
endmodule // pkh_host_properties

// ===== tb/pkh_peer.sv
// Behavioural keyboard/mouse on the far side of the two-wire link.
// Assumes wired-AND lines resolved by the bench; 160 ns link clock.
`timescale 1ns/10ps
module pkh_peer
(
  input  wire logic clk_line,
  input  wire logic dat_line,
  output logic      clk_oe = 1'b0,
  output logic      dat_oe = 1'b0
);
  logic [7:0] last_rx = 8'h00;
  logic [7:0] last_tx = 8'h00;
  logic       par_ok  = 1'b0;
  logic       busy    = 1'b0;

  // One link clock period; data only moves mid-high
  task automatic pulse();
    #40 clk_oe = 1'b1;
    #80 clk_oe = 1'b0;
    #40;
  endtask

  task automatic send_byte(input logic [7:0] b, input logic bad_par);
    logic [10:0] f;
    f = {1'b1, ~(^b) ^ bad_par, b, 1'b0};
    wait (clk_line && dat_line);
    busy = 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      dat_oe = ~f[i];
      pulse();
    end
    dat_oe = 1'b0;
    busy = 1'b0;
  endtask

  task automatic send_key(input logic [7:0] b, input logic bad_par);
    send_byte(b, bad_par);
    last_tx = b;
  endtask

  task automatic receive();
    logic [9:0] f;
    busy = 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      #40 clk_oe = 1'b1;
      #80 clk_oe = 1'b0;
      f[i] = dat_line;
      #40;
    end
    dat_oe = 1'b1;
    pulse();
    dat_oe = 1'b0;
    busy = 1'b0;
    last_rx = f[7:0];
    par_ok = ^f[8:0];
    if (f[7:0] == 8'hEE)
      send_byte(8'hEE, 1'b0);
    else if (f[7:0] == 8'hFE)
      send_byte(last_tx, 1'b0);
    else
      send_byte(8'hFA, 1'b0);
  endtask

  // Host request: clock held low, then released with data low
  always
  begin
    wait (!clk_line && !clk_oe && !busy);
    wait (clk_line);
    #20;
    // Own word just starting is not a host request
    if (!dat_line && !busy)
      receive();
  end
endmodule // pkh_peer

// ===== tb/pkh_host_test.sv
// Self-checking bench for pkh_host: Wishbone master tasks, link peer model.
// Assumes 100 MHz clock; inhibit and timeout counts shortened.
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    total_checks++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end \
  end
module pkh_host_test
  import pkh_pkg::*;
;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] seed = 32'h0000_43B7;
  logic [31:0] rd, wb_dat_o;
  logic        wb_ack_o, pclk_oe, pdat_oe, m_clk_oe, m_dat_oe;
  logic [7:0]  code, s, x, y, sh;
  int          bad_count = 0;
  int          total_checks = 0;
  wire         clk_line = !(pclk_oe || m_clk_oe);
  wire         dat_line = !(pdat_oe || m_dat_oe);

  always #5 clk_i = ~clk_i;

  pkh_host #(.INHIBIT_CYC_P(20), .FRAME_TMO_P(5000), .TX_TMO_P(20000)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ps2_clk_i(clk_line), .ps2_clk_o(), .ps2_clk_oe_o(pclk_oe),
    .ps2_dat_i(dat_line), .ps2_dat_o(), .ps2_dat_oe_o(pdat_oe));

  pkh_peer peer (.clk_line(clk_line), .dat_line(dat_line), .clk_oe(m_clk_oe), .dat_oe(m_dat_oe));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] key_exp(input logic [7:0] c, input logic rel, input logic ext, input logic shf);
    return {21'h0, shf, ext, rel, c};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic poll(input int idx, input logic val);
    int n;
    n = 0;
    do
    begin
      wb(1'b0, ADR_STAT, 32'h0);
      n++;
    end
    while (rd[idx] !== val && n < 3000);
    `CHK("status bit", val, rd[idx])
  endtask

  // Flags cleared before the last byte so earlier events cannot satisfy the poll
  task automatic key_seq(input logic [31:0] seq, input int n, input logic [31:0] e);
    for (int i = n - 1; i > 0; i--)
      peer.send_key(seq[8*i +: 8], 1'b0);
    wb(1'b1, ADR_STAT, 32'h3F);
    peer.send_key(seq[7:0], 1'b0);
    poll(ST_KEY, 1'b1);
    wb(1'b0, ADR_KEY, 32'h0);
    `CHK("key", e, rd)
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] arg, input int flag);
    wb(1'b1, ADR_ARG, {24'h0, arg});
    wb(1'b1, ADR_TX, {24'h0, c});
    poll(6, 1'b0);
    `CHK("tx done error", 1'b0, rd[ST_TXERR])
    wb(1'b1, ADR_STAT, 32'h3F);
    poll(flag, 1'b1);
    `CHK("tx error", 1'b0, rd[ST_TXERR])
    `CHK("peer byte", (c == CMD_LED || c == CMD_RATE) ? arg : c, peer.last_rx)
    `CHK("peer parity", 1'b1, peer.par_ok)
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK("clk drive", 1'b0, pclk_oe)
    `CHK("dat drive", 1'b0, pdat_oe)
    wb(1'b0, ADR_STAT, 32'h0);
    `CHK("status", 32'h0, rd)
    wb(1'b0, ADR_CTRL, 32'h0);
    `CHK("ctrl", 32'h0, rd)
    wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
    wb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    sel <= 4'hE;
    wb(1'b1, ADR_ARG, 32'h0000_00FF);
    sel <= 4'hF;
    wb(1'b0, ADR_ARG, 32'h0);
    `CHK("sel ignored", 32'h0, rd)
    wb(1'b1, ADR_STAT, 32'h3F);
    peer.send_key(8'h1C, 1'b1);
    poll(ST_ERR, 1'b1);
    `CHK("key flag", 1'b0, rd[ST_KEY])
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr(seed);
      code = 8'h13 + {2'b00, seed[5:0]};
      sh = k[0] ? SHIFT_RIGHT : SHIFT_LEFT;
      key_seq({24'h0, code}, 1, key_exp(code, 0, 0, 0));
      key_seq({24'h0, code}, 1, key_exp(code, 0, 0, 0));
      key_seq({16'h0, CODE_RELEASE, code}, 2, key_exp(code, 1, 0, 0));
      key_seq({16'h0, CODE_EXT, code}, 2, key_exp(code, 0, 1, 0));
      key_seq({8'h0, CODE_EXT, CODE_RELEASE, code}, 3, key_exp(code, 1, 1, 0));
      key_seq({16'h0, sh, code}, 2, key_exp(code, 0, 0, 1));
      key_seq({8'h0, CODE_RELEASE, sh, code}, 3, key_exp(code, 0, 0, 0));
    end
    wb(1'b1, ADR_CTRL, 32'h1);
    wb(1'b1, ADR_STAT, 32'h3F);
    fork
      peer.send_key(code, 1'b0);
    join_none
    repeat (200) @(posedge clk_i);
    `CHK("clk held", 1'b1, pclk_oe)
    wb(1'b0, ADR_STAT, 32'h0);
    `CHK("no word", 1'b0, rd[ST_KEY])
    wb(1'b1, ADR_CTRL, 32'h0);
    poll(ST_KEY, 1'b1);
    cmd(CMD_LED, seed[7:0], ST_ACK);
    cmd(CMD_RATE, seed[15:8], ST_ACK);
    cmd(CODE_ECHO, 8'h00, ST_ECHO);
    cmd(8'hFF, 8'h00, ST_ACK);
    cmd(8'hFE, 8'h00, ST_KEY);
    wb(1'b0, ADR_KEY, 32'h0);
    `CHK("resent key", key_exp(code, 0, 0, 0), rd)
    wb(1'b1, ADR_CTRL, 32'h2);
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr(seed);
      s = {seed[7:4], 1'b1, seed[2:0]};
      x = seed[15:8];
      y = seed[23:16];
      wb(1'b1, ADR_STAT, 32'h3F);
      if (k == 0)
        peer.send_key(8'h00, 1'b0);
      peer.send_key(s, 1'b0);
      peer.send_key(x, 1'b0);
      peer.send_key(y, 1'b0);
      poll(ST_MOUSE, 1'b1);
      wb(1'b0, ADR_MXY, 32'h0);
      `CHK("motion", {7'h0, s[5], y, 7'h0, s[4], x}, rd)
      wb(1'b0, ADR_MBTN, 32'h0);
      `CHK("buttons", {18'h0, s[7], s[6], s[5], s[4], s[1], s[0], s}, rd)
    end
    stop_test();
  end

  // Whole run needs about 13000 cycles
  initial
  begin
    repeat (80000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end
endmodule // pkh_host_test

bind pkh_host pkh_host_properties #(.INHIBIT_CYC_P(INHIBIT_CYC_P)) chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ps2_clk_i(ps2_clk_i),
  .ps2_clk_o(ps2_clk_o), .ps2_clk_oe_o(ps2_clk_oe_o), .ps2_dat_o(ps2_dat_o), .ps2_dat_oe_o(ps2_dat_oe_o));
